/* File: core/mema_pkg.sv */
// holds the shared constants of the mac event block and its flag bank
// assumes one bus clock and a synchronous active-low system reset
// ----------------------------------------
// constants
// ----------------------------------------
package mema_pkg;
  localparam int          ADDR_W      = 8;
  localparam int          FLAG_W      = 16;
  // register indices; byte address is four times the index
  localparam logic [7:0]  IDX_FLAGS   = 8'h0a;
  localparam logic [7:0]  IDX_ENABLES = 8'h0c;
  localparam logic [7:0]  IDX_SOFTRST = 8'h0e;
  localparam logic [7:0]  IDX_PHY_SEL = 8'h10;
  localparam logic [7:0]  IDX_REG_SEL = 8'h11;
  localparam logic [7:0]  IDX_MGMT    = 8'h16;
  localparam logic [7:0]  IDX_MAXLEN  = 8'h18;
  // event bit positions, shared by flags and enables
  localparam int          B_FLOW      = 15;
  localparam int          B_BABBLE    = 14;
  localparam int          B_RXERR     = 13;
  localparam int          B_A_OVR     = 12;
  localparam int          B_B_OVR     = 11;
  localparam int          B_A_DONE    = 10;
  localparam int          B_B_DONE    = 9;
  localparam int          B_MGMT      = 8;
  localparam int          B_LATE      = 7;
  localparam int          B_EXCESS    = 6;
  localparam int          B_TX_DONE   = 5;
  localparam logic [15:0] FLAG_IMPL   = 16'hffe0;
  // reset values
  localparam logic [15:0] RST_FLAGS   = 16'h0000;
  localparam logic [15:0] RST_ENABLES = 16'h0000;
  localparam logic [4:0]  RST_PHY     = 5'h00;
  localparam logic [4:0]  RST_REG     = 5'h00;
  localparam logic [10:0] RST_MAXLEN  = 11'h5ee;
  localparam logic [3:0]  RST_DIV     = 4'h0;
  // field positions
  localparam int          RST_BIT     = 0;
  localparam int          OP_LSB      = 6;
  localparam int          BUSY_BIT    = 5;
  localparam int          NOPRE_BIT   = 4;
  // receive length clamp and collision limits
  localparam logic [10:0] MAXLEN_MIN  = 11'h040;
  localparam logic [10:0] MAXLEN_MAX  = 11'h5ee;
  localparam logic [15:0] COLL_WINDOW = 16'h0200;
  localparam logic [4:0]  RETRY_MAX   = 5'h0f;
  // management opcodes and bus answers
  localparam logic [1:0]  OP_WRITE    = 2'h1;
  localparam logic [1:0]  OP_READ     = 2'h2;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage : mema_pkg

/* File: core/mema_flag_bank.sv */
// holds the sticky event flags, one write-one-to-clear cell per implemented bit; reserved bits read zero
// assumes set strobes and clear masks are synchronous to clock
`timescale 1ns/100ps
`default_nettype none
module mema_flag_bank
  import mema_pkg::*;
#(
  parameter int          WIDTH = FLAG_W,
  parameter logic [15:0] IMPL  = FLAG_IMPL
) (
  // clock and local reset
  input  wire logic             clock,
  input  wire logic             clear,
  // events and software clears
  input  wire logic [WIDTH-1:0] set_stb,
  input  wire logic [WIDTH-1:0] clr_mask,
  // state
  output logic      [WIDTH-1:0] flags
);
  // ----------------------------------------
  // flag cells
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_cell
      if (IMPL[i]) begin : g_impl
        always_ff @(posedge clock) begin
          if (clear)
            flags[i] <= RST_FLAGS[i];
          else if (set_stb[i])
            flags[i] <= 1'b1;
          else if (clr_mask[i])
            flags[i] <= 1'b0;
        end
      end else begin : g_rsvd
        assign flags[i] = 1'b0;
      end
    end
  endgenerate
endmodule : mema_flag_bank
`default_nettype wire

/* File: core/mema_event_ctrl.sv */
// event flags, enables, local reset and management address registers
// assumes an axi4-lite master on clock and one-cycle datapath strobes
//
// Contract
// - flag and enable raise request
// - write one clears flag, zero ignored
// - request holds until flag or enable cleared
// - pause frame sets flow flag
// - overlong frame sets babble flag
// - phy, length, alignment, crc errors flag
// - per-buffer overrun flags
// - per-buffer frame done flags
// - management transfer end sets flag
// - late collision past 512 bits flagged
// - more than 15 collisions flagged
// - frame discarded, start needed again
// - transmit done sets flag
// - one read-write enable per flag
// - reset bit restores all registers
// - local reset aborts frames now
// - reset bit write zero ignored, reads zero
// - phy select five bits, reset zero
// - register select five bits, reset zero
// - busy from opcode until done flag
// - max length clamped 0x040 to 0x5ee
`timescale 1ns/100ps
`default_nettype none
module mema_event_ctrl
  import mema_pkg::*;
(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // receive events
  input  wire logic              pause_rx_stb,
  input  wire logic              rx_len_stb,
  input  wire logic [10:0]       rx_frame_len,
  input  wire logic              rx_phy_err_stb,
  input  wire logic              rx_len_mismatch_stb,
  input  wire logic              rx_align_err_stb,
  input  wire logic              rx_crc_err_stb,
  input  wire logic [1:0]        rx_overrun_stb,
  input  wire logic [1:0]        rx_done_stb,
  // transmit events
  input  wire logic              half_duplex,
  input  wire logic              tx_start_cmd,
  input  wire logic              collision_stb,
  input  wire logic [15:0]       tx_bit_count,
  input  wire logic              tx_done_stb,
  // management engine
  input  wire logic              mgmt_xfer_done_stb,
  output logic                   mgmt_start,
  output logic [1:0]             mgmt_op,
  output logic                   mgmt_busy,
  output logic [4:0]             mgmt_phy_select,
  output logic [4:0]             mgmt_reg_select,
  output logic                   mgmt_nopre,
  output logic [3:0]             mgmt_clk_div,
  // datapath control
  output logic                   mac_reset_pulse,
  output logic                   tx_halted,
  output logic                   tx_discard,
  output logic [10:0]            max_rx_frame_len,
  // request
  output logic                   irq
);
  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] idx);
    hit = (a[ADDR_W-1:2] == idx[ADDR_W-3:0]);
  endfunction : hit

  function automatic logic [15:0] lanes(input logic [3:0] strb);
    lanes = {{8{strb[1]}}, {8{strb[0]}}};
  endfunction : lanes

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [15:0] flags;
  logic [15:0] event_enables;
  logic [4:0]  phy_sel;
  logic [4:0]  reg_sel;
  logic [10:0] max_len_raw;
  logic [3:0]  clk_div;
  logic        nopre;
  logic        busy;
  logic [4:0]  coll_cnt;
  logic        aw_held;
  logic        w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        local_clr;

  // ----------------------------------------
  // write channel
  // ----------------------------------------
  wire aw_fire  = s_axi_awvalid & s_axi_awready;
  wire w_fire   = s_axi_wvalid & s_axi_wready;
  wire do_write = aw_held & w_held & ~s_axi_bvalid;
  wire [15:0] hmask = w_data[15:0] & lanes(w_strb);
  wire wr_flags = do_write & hit(aw_addr, IDX_FLAGS);
  wire wr_en    = do_write & hit(aw_addr, IDX_ENABLES);
  wire wr_rst   = do_write & hit(aw_addr, IDX_SOFTRST);
  wire wr_phy   = do_write & hit(aw_addr, IDX_PHY_SEL) & w_strb[0];
  wire wr_reg   = do_write & hit(aw_addr, IDX_REG_SEL) & w_strb[0];
  wire wr_mgmt  = do_write & hit(aw_addr, IDX_MGMT) & w_strb[0];
  wire wr_len   = do_write & hit(aw_addr, IDX_MAXLEN);
  wire wr_known = hit(aw_addr, IDX_FLAGS) | hit(aw_addr, IDX_ENABLES)
                | hit(aw_addr, IDX_SOFTRST) | hit(aw_addr, IDX_PHY_SEL)
                | hit(aw_addr, IDX_REG_SEL) | hit(aw_addr, IDX_MGMT)
                | hit(aw_addr, IDX_MAXLEN);

  assign s_axi_awready = ~aw_held;
  assign s_axi_wready  = ~w_held;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
    end else begin
      if (aw_fire) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write)
        aw_held <= 1'b0;
      if (w_fire) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write)
        w_held <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ----------------------------------------
  // local reset
  // ----------------------------------------
  // one-cycle local reset
  // only a one acts
  // one cycle is enough: every register on local_clr clears synchronously; the bus channel registers keep their state
  always_ff @(posedge clock) begin
    if (!rst_n)
      mac_reset_pulse <= 1'b0;
    else
      mac_reset_pulse <= wr_rst & w_strb[0] & w_data[RST_BIT];
  end
  assign local_clr = ~rst_n | mac_reset_pulse;

  // ----------------------------------------
  // event sources
  // ----------------------------------------
  // clamp programmed length
  assign max_rx_frame_len = (max_len_raw <= MAXLEN_MIN) ? MAXLEN_MIN :
                            (max_len_raw >= MAXLEN_MAX) ? MAXLEN_MAX :
                            max_len_raw;
  wire babble_ev = rx_len_stb & (rx_frame_len > max_rx_frame_len);
  wire rxerr_ev  = rx_phy_err_stb | rx_len_mismatch_stb
                 | rx_align_err_stb | rx_crc_err_stb;
  wire hd_coll   = collision_stb & half_duplex;
  wire late_ev   = hd_coll & (tx_bit_count >= COLL_WINDOW);
  wire excess_ev = hd_coll & (coll_cnt == RETRY_MAX);

  logic [15:0] set_stb;
  always_comb begin
    set_stb            = '0;
    set_stb[B_FLOW]    = pause_rx_stb;
    set_stb[B_BABBLE]  = babble_ev;
    set_stb[B_RXERR]   = rxerr_ev;
    set_stb[B_A_OVR]   = rx_overrun_stb[0];
    set_stb[B_B_OVR]   = rx_overrun_stb[1];
    set_stb[B_A_DONE]  = rx_done_stb[0];
    set_stb[B_B_DONE]  = rx_done_stb[1];
    set_stb[B_MGMT]    = mgmt_xfer_done_stb & busy;
    set_stb[B_LATE]    = late_ev;
    set_stb[B_EXCESS]  = excess_ev;
    set_stb[B_TX_DONE] = tx_done_stb;
  end

  wire [15:0] clr_mask = wr_flags ? hmask : 16'h0000;

  mema_flag_bank #(
    .WIDTH (FLAG_W),
    .IMPL  (FLAG_IMPL)
  ) u_flags (
    .clock    (clock),
    .clear    (local_clr),
    .set_stb  (set_stb),
    .clr_mask (clr_mask),
    .flags    (flags)
  );

  // ----------------------------------------
  // collisions and discard
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (local_clr | tx_start_cmd)
      coll_cnt <= '0;
    else if (hd_coll && coll_cnt != RETRY_MAX + 5'h01)
      coll_cnt <= coll_cnt + 5'h01;
  end
  always_ff @(posedge clock) begin
    if (local_clr) begin
      tx_halted  <= 1'b0;
      tx_discard <= 1'b0;
    end else begin
      tx_discard <= excess_ev;
      if (excess_ev)
        tx_halted <= 1'b1;
      else if (tx_start_cmd)
        tx_halted <= 1'b0;
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  wire [1:0] wr_op   = w_data[OP_LSB+1:OP_LSB];
  wire       op_ok   = wr_mgmt & ~busy & (clk_div != 4'h0)
                     & (wr_op == OP_WRITE || wr_op == OP_READ);

  always_ff @(posedge clock) begin
    if (local_clr) begin
      event_enables <= RST_ENABLES;
      phy_sel       <= RST_PHY;
      reg_sel       <= RST_REG;
      max_len_raw   <= RST_MAXLEN;
      clk_div       <= RST_DIV;
      nopre         <= 1'b0;
    end else begin
      if (wr_en)
        event_enables <= (event_enables & ~lanes(w_strb))
                       | (w_data[15:0] & lanes(w_strb) & FLAG_IMPL);
      if (wr_phy)
        phy_sel <= w_data[4:0];
      if (wr_reg)
        reg_sel <= w_data[4:0];
      if (wr_len && w_strb[0])
        max_len_raw[7:0] <= w_data[7:0];
      if (wr_len && w_strb[1])
        max_len_raw[10:8] <= w_data[10:8];
      if (wr_mgmt && !busy) begin
        clk_div <= w_data[3:0];
        nopre   <= w_data[NOPRE_BIT];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (local_clr) begin
      busy       <= 1'b0;
      mgmt_start <= 1'b0;
      mgmt_op    <= 2'h0;
    end else begin
      mgmt_start <= op_ok;
      if (op_ok) begin
        busy    <= 1'b1;
        mgmt_op <= wr_op;
      end else if (mgmt_xfer_done_stb)
        busy <= 1'b0;
    end
  end

  assign mgmt_busy       = busy;
  assign mgmt_phy_select = phy_sel;
  assign mgmt_reg_select = reg_sel;
  assign mgmt_nopre      = nopre;
  assign mgmt_clk_div    = clk_div;

  // ----------------------------------------
  // request
  // ----------------------------------------
  // or of enabled flags
  // falls only with flag or enable
  assign irq = |(flags & event_enables);

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  wire [15:0] mgmt_rd = {8'h00, 2'h0, busy, nopre, clk_div};
  wire [31:0] rd_mux  =
    hit(s_axi_araddr, IDX_FLAGS)   ? {16'h0000, flags} :
    hit(s_axi_araddr, IDX_ENABLES) ? {16'h0000, event_enables} :
    hit(s_axi_araddr, IDX_PHY_SEL) ? {27'h000_0000, phy_sel} :
    hit(s_axi_araddr, IDX_REG_SEL) ? {27'h000_0000, reg_sel} :
    hit(s_axi_araddr, IDX_MGMT)    ? {16'h0000, mgmt_rd} :
    hit(s_axi_araddr, IDX_MAXLEN)  ? {21'h00_0000, max_len_raw} :
                                     32'h0000_0000;
  wire rd_known = hit(s_axi_araddr, IDX_FLAGS)
                | hit(s_axi_araddr, IDX_ENABLES)
                | hit(s_axi_araddr, IDX_SOFTRST)
                | hit(s_axi_araddr, IDX_PHY_SEL)
                | hit(s_axi_araddr, IDX_REG_SEL)
                | hit(s_axi_araddr, IDX_MGMT)
                | hit(s_axi_araddr, IDX_MAXLEN);

  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  irq_source_a : assert property (
    @(posedge clock) disable iff (!rst_n)
    irq == |(flags & event_enables))
    else $error("request does not match flags and enables");

  w1c_clear_a : assert property (
    @(posedge clock) disable iff (!rst_n)
    wr_flags && !mac_reset_pulse && clr_mask[B_TX_DONE]
      && !set_stb[B_TX_DONE] |=> !flags[B_TX_DONE])
    else $error("write one did not clear flag");

  irq_hold_a : assert property (
    @(posedge clock) disable iff (!rst_n)
    irq && !wr_flags && !wr_en && !mac_reset_pulse |=> irq)
    else $error("request dropped without a clear");

  set_wins_a : assert property (
    @(posedge clock) disable iff (!rst_n)
    set_stb[B_RXERR] && !mac_reset_pulse |=> flags[B_RXERR])
    else $error("event lost against clear");

  babble_set_a : assert property (
    @(posedge clock) disable iff (!rst_n)
    rx_len_stb && rx_frame_len > max_rx_frame_len
      && !mac_reset_pulse |=> flags[B_BABBLE])
    else $error("overlong frame not flagged");

  excess_set_a : assert property (
    @(posedge clock) disable iff (!rst_n)
    tx_start_cmd ##1 (!tx_start_cmd && !mac_reset_pulse
      && hd_coll)[*8] ##1 (!tx_start_cmd && !mac_reset_pulse
      && hd_coll)[*8] |=> flags[B_EXCESS] && tx_halted)
    else $error("sixteenth collision not flagged");

  busy_clear_a : assert property (
    @(posedge clock) disable iff (!rst_n)
    busy && mgmt_xfer_done_stb && !op_ok && !mac_reset_pulse
      |=> !busy && flags[B_MGMT])
    else $error("busy not cleared with done flag");

  len_clamp_a : assert property (
    @(posedge clock) disable iff (!rst_n)
    max_rx_frame_len >= MAXLEN_MIN && max_rx_frame_len <= MAXLEN_MAX)
    else $error("receive length outside clamp");

  soft_rst_a : assert property (
    @(posedge clock) disable iff (!rst_n)
    mac_reset_pulse |=> flags == RST_FLAGS
      && event_enables == RST_ENABLES && phy_sel == RST_PHY)
    else $error("local reset left state behind");
endmodule : mema_event_ctrl
`default_nettype wire

/* File: dv/mema_mgmt_model.sv */
// management engine stand-in that finishes each requested transfer
// assumes a one-cycle start pulse from the event block on clock
`timescale 1ns/100ps
`default_nettype none
module mema_mgmt_model
  import mema_pkg::*;
#(
  parameter int DELAY = 20
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // engine handshake
  input  wire logic start,
  output var  logic done_stb
);
  int cnt;
  // ----------------------------------------
  // transfer timer
  // ----------------------------------------
  // done after transfer time
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt      <= 0;
      done_stb <= 1'b0;
    end else begin
      done_stb <= (cnt == 1);
      if (start) begin
        cnt <= DELAY;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule : mema_mgmt_model
`default_nettype wire

/* File: dv/mema_event_ctrl_tb.sv */
// self-checking bench for the mac event and management address block
// assumes the engine model above; registers reached over axi4-lite
`timescale 1ns/100ps
`default_nettype none
module mema_event_ctrl_tb
  import mema_pkg::*;
;
  localparam logic [7:0] A_FLG = IDX_FLAGS << 2;
  localparam logic [7:0] A_EN  = IDX_ENABLES << 2;
  localparam logic [7:0] A_RST = IDX_SOFTRST << 2;
  localparam logic [7:0] A_PHY = IDX_PHY_SEL << 2;
  localparam logic [7:0] A_REG = IDX_REG_SEL << 2;
  localparam logic [7:0] A_MGT = IDX_MGMT << 2;
  localparam logic [7:0] A_MAX = IDX_MAXLEN << 2;
  logic        clock, rst_n, awvalid, wvalid, bready, arvalid, rready, hd;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rv;
  logic [1:0]  rr;
  logic [12:0] stb;
  logic [10:0] flen;
  logic [15:0] bits;
  wire         awready, wready, bvalid, arready, rvalid;
  wire         irq, busy, mstart, halted, done_stb;
  wire         nopre, mrst, discard;
  wire  [1:0]  bresp, rresp, mop;
  wire  [3:0]  mdiv;
  wire  [31:0] rdata;
  wire  [4:0]  phy, rsel;
  wire  [10:0] maxlen;
  int          err_total = 0;
  int          num_checks = 0;
  int          fb[12] = '{B_FLOW, B_BABBLE, B_RXERR, B_RXERR, B_RXERR,
    B_RXERR, B_A_OVR, B_B_OVR, B_A_DONE, B_B_DONE, B_LATE, B_TX_DONE};
  logic [10:0] mw[4] = '{11'h010, 11'h7ff, 11'h041, 11'h100};
  logic [10:0] me[4] = '{11'h040, 11'h5ee, 11'h041, 11'h100};

  mema_event_ctrl dut (
    .clock(clock), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pause_rx_stb(stb[0]), .rx_len_stb(stb[1]), .rx_frame_len(flen),
    .rx_phy_err_stb(stb[2]), .rx_len_mismatch_stb(stb[3]),
    .rx_align_err_stb(stb[4]), .rx_crc_err_stb(stb[5]),
    .rx_overrun_stb(stb[7:6]), .rx_done_stb(stb[9:8]),
    .half_duplex(hd), .tx_start_cmd(stb[12]), .collision_stb(stb[10]),
    .tx_bit_count(bits), .tx_done_stb(stb[11]),
    .mgmt_xfer_done_stb(done_stb), .mgmt_start(mstart), .mgmt_op(mop),
    .mgmt_busy(busy), .mgmt_phy_select(phy), .mgmt_reg_select(rsel),
    .mgmt_nopre(nopre), .mgmt_clk_div(mdiv), .mac_reset_pulse(mrst),
    .tx_halted(halted), .tx_discard(discard), .max_rx_frame_len(maxlen),
    .irq(irq)
  );
  mema_mgmt_model model (.clock(clock), .rst_n(rst_n), .start(mstart),
    .done_stb(done_stb));

  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // leading edge keeps two drives of one signal apart
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rr = bresp;
    bready <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge clock);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rv = rdata; rr = rresp;
    rready <= 1'b0;
  endtask : rd
  task rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rv, e);
  endtask : rchk
  task pulse(input int i);
    @(posedge clock);
    stb <= 13'h1 << i;
    @(posedge clock);
    stb <= 13'h0;
    @(posedge clock);
  endtask : pulse
  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------
  // clock, watchdog and tests
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    tally_and_finish;
  end
  initial begin
    rst_n = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00;
    wdata = 32'h0; stb = 13'h0; hd = 1'b1; flen = 11'h5ef;
    bits = 16'h0200;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    rchk(A_FLG, 32'h0); rchk(A_EN, 32'h0);
    rchk(A_PHY, 32'h0); rchk(A_REG, 32'h0);
    rchk(A_MAX, 32'h5ee);
    rd(8'h04); chk(rr, RESP_SLVERR); chk(rv, 32'h0);
    wr(8'h04, 32'hffff_ffff); chk(rr, RESP_SLVERR);
    for (int i = 0; i < 12; i++) begin
      pulse(i);
      rchk(A_FLG, 32'h1 << fb[i]);
      chk(irq, 1'b0);
      wr(A_FLG, 32'h1 << fb[i]);
      rchk(A_FLG, 32'h0);
    end
    // event strobe lands on the clearing edge of the write
    fork
      wr(A_FLG, 32'h1 << B_RXERR);
      begin
        repeat (2) @(posedge clock);
        stb <= 13'h1 << 2;
        @(posedge clock);
        stb <= 13'h0;
      end
    join
    rchk(A_FLG, 32'h1 << B_RXERR);
    wr(A_FLG, 32'hffff);
    flen <= 11'h5ee; bits <= 16'h01ff;
    pulse(1); pulse(10);
    rchk(A_FLG, 32'h0);
    // full duplex: a late collision must not flag
    hd <= 1'b0;
    bits <= 16'h0200;
    pulse(10);
    rchk(A_FLG, 32'h0);
    hd <= 1'b1;
    pulse(12); bits <= 16'h0000;
    repeat (15) pulse(10);
    rchk(A_FLG, 32'h0);
    pulse(10);
    rchk(A_FLG, 32'h1 << B_EXCESS);
    chk(halted, 1'b1);
    wr(A_FLG, 32'hffff); pulse(12);
    chk(halted, 1'b0);
    // sixteen collisions back to back after a start
    @(posedge clock);
    stb <= 13'h1 << 12;
    @(posedge clock);
    stb <= 13'h1 << 10;
    repeat (16) @(posedge clock);
    stb <= 13'h0;
    @(posedge clock);
    chk(discard, 1'b1);
    chk(halted, 1'b1);
    rchk(A_FLG, 32'h1 << B_EXCESS);
    wr(A_FLG, 32'hffff);
    pulse(12);
    wr(A_EN, 32'hffff); rchk(A_EN, FLAG_IMPL);
    wr(A_EN, 32'h1 << B_TX_DONE); pulse(11);
    chk(irq, 1'b1);
    wr(A_FLG, 32'h0); rchk(A_FLG, 32'h1 << B_TX_DONE);
    chk(irq, 1'b1);
    wr(A_EN, 32'h0); chk(irq, 1'b0);
    wr(A_EN, 32'h1 << B_TX_DONE); chk(irq, 1'b1);
    wr(A_FLG, 32'h1 << B_TX_DONE); chk(irq, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(A_MAX, {21'h0, mw[i]}); chk(maxlen, me[i]);
    end
    flen <= 11'h101; pulse(1);
    rchk(A_FLG, 32'h1 << B_BABBLE);
    wr(A_FLG, 32'hffff);
    // selects written while the engine is idle; the block accepts them whether or not busy is set
    wr(A_PHY, 32'h1f); rchk(A_PHY, 32'h1f); chk(phy, 5'h1f);
    wr(A_REG, 32'h15); rchk(A_REG, 32'h15); chk(rsel, 5'h15);
    // divider first: an opcode is ignored while the divider is zero
    wr(A_MGT, 32'h1a);
    chk(busy, 1'b0);
    chk(nopre, 1'b1);
    chk(mdiv, 4'ha);
    wr(A_MGT, {24'h0, OP_READ, 6'h0a}); chk(busy, 1'b1);
    chk(mstart, 1'b1);
    chk(mop, OP_READ);
    chk(nopre, 1'b0);
    rchk(A_MGT, 32'h2a);
    rchk(A_FLG, 32'h0);
    while (busy) @(posedge clock);
    rchk(A_FLG, 32'h1 << B_MGMT);
    wr(A_EN, 32'hffff); pulse(0);
    wr(A_RST, 32'h0); chk(mrst, 1'b0);
    rchk(A_EN, FLAG_IMPL);
    wr(A_RST, 32'h1); chk(mrst, 1'b1); // issued while idle
    repeat (2) @(posedge clock);
    rchk(A_RST, 32'h0);
    rchk(A_FLG, 32'h0); rchk(A_EN, 32'h0);
    rchk(A_PHY, 32'h0); rchk(A_REG, 32'h0);
    chk(maxlen, 11'h5ee); chk(irq, 1'b0);
    tally_and_finish;
  end
endmodule : mema_event_ctrl_tb
`default_nettype wire
